// ---- logic/snr_map.svh ----
// register numbers, reset values and fixed counts of the sensor node register bank
// Notes on behaviour
// RULE1 - station address resets to 254 unless stored
// RULE2 - speed codes 0..4 select 9600..115200 bps
// RULE3 - serial id at bytes 0..3, read only
// RULE4 - software version read only at 4..5
// RULE5 - product model byte ignores writes
// RULE6 - hardware revision byte ignores writes
// RULE7 - writable conflict resolution slot for master
// RULE8 - status byte reports firmware update progress
// RULE9 - thermistor and light samples read only
// RULE10 - writing gas concentration requests calibration
// RULE11 - offset writable, recomputed on concentration write
// RULE12 - reject spikes above threshold, default 200
// RULE13 - smooth over configurable passes, default 5
// RULE14 - fair and poor thresholds drive alarm
// RULE15 - alarm bit3 poor, bit2 fair, bit1 good
// RULE16 - humidity element frequency read only
// RULE17 - humidity calibration point count register
// RULE18 - element temperature in Celsius and Fahrenheit together
// RULE19 - read only writes ignored, still acknowledged
// RULE20 - reserved range reads zero, ignores writes
`ifndef SNR_MAP_SVH
`define SNR_MAP_SVH

// register numbers as seen by the network master
`define SNR_OFS_SERIAL0    8'h00
`define SNR_OFS_SERIAL1    8'h01
`define SNR_OFS_SERIAL2    8'h02
`define SNR_OFS_SERIAL3    8'h03
`define SNR_OFS_SWVER_LO   8'h04
`define SNR_OFS_SWVER_HI   8'h05
`define SNR_OFS_STATION    8'h06
`define SNR_OFS_MODEL      8'h07
`define SNR_OFS_HWREV      8'h08
`define SNR_OFS_CTLFW      8'h09
`define SNR_OFS_CONFLICT   8'h0A
`define SNR_OFS_SPEED      8'h0F
`define SNR_OFS_UPDATE     8'h10
`define SNR_OFS_RSVD_LO    8'h11
`define SNR_OFS_RSVD_HI    8'h63
`define SNR_OFS_RAW_GAS_V  8'h64
`define SNR_OFS_RAW_TMP_V  8'h65
`define SNR_OFS_RAW_HUM_V  8'h66
`define SNR_OFS_RAW_GAS_I  8'h67
`define SNR_OFS_RAW_TMP_I  8'h68
`define SNR_OFS_RAW_HUM_I  8'h69
`define SNR_OFS_RAW_THERM  8'h6A
`define SNR_OFS_RAW_LIGHT  8'h6B
`define SNR_OFS_GAS_CONC   8'h6C
`define SNR_OFS_GAS_OFS    8'h6D
`define SNR_OFS_SPIKE      8'h6E
`define SNR_OFS_PASSES     8'h6F
`define SNR_OFS_FAIR       8'h70
`define SNR_OFS_POOR       8'h71
`define SNR_OFS_ALARM      8'h72
`define SNR_OFS_HUM_VER    8'h73
`define SNR_OFS_RH         8'h74
`define SNR_OFS_HUM_FREQ   8'h75
`define SNR_OFS_HUM_CAL    8'h76
`define SNR_OFS_HUM_TC     8'h77
`define SNR_OFS_HUM_TF     8'h78
`define SNR_OFS_THERM_TC   8'h79

// reset values
`define SNR_RST_STATION    8'hFE
`define SNR_RST_SPIKE      8'hC8
`define SNR_RST_PASSES     16'h0005
`define SNR_RST_SPEED      8'h00
`define SNR_RST_FAIR       16'h03E8
`define SNR_RST_POOR       16'h05DC

// line speed table, bits per second
`define SNR_SPEED_MAX      8'h04
`define SNR_BPS_0          17'h02580
`define SNR_BPS_1          17'h04B00
`define SNR_BPS_2          17'h09600
`define SNR_BPS_3          17'h0E100
`define SNR_BPS_4          17'h1C200

// alarm bit positions
`define SNR_ALARM_POOR     3
`define SNR_ALARM_FAIR     2
`define SNR_ALARM_GOOD     1

// tenths of a degree: f = c * 9 / 5 + 320
`define SNR_F_MUL          20'sh00009
`define SNR_F_DIV          20'sh00005
`define SNR_F_ADD          20'sh00140

// consecutive spikes after which the filter follows the new level
`define SNR_SPIKE_RESEED   3'h4

`endif

// ---- logic/snr_pkg.sv ----
// types shared by the sensor node register bank
package snr_pkg;

  typedef logic [15:0] snr_word_t;
  typedef logic [7:0]  snr_byte_t;

  // gas filter progress
  typedef enum logic [0:0] {
    FLT_EMPTY,
    FLT_RUN
  } snr_flt_state_e;

endpackage

// ---- logic/snr_filter.sv ----
// spike rejection and smoothing of the gas concentration samples
`timescale 1ns/1ps
`include "snr_map.svh"

module snr_filter (
  input  wire logic             i_clock,        // node clock
  input  wire logic             i_rst_n,        // synchronous reset, active low
  input  wire logic             i_sample_valid, // one-cycle sample strobe
  input  wire snr_pkg::snr_word_t i_sample,     // raw ppm sample
  input  wire snr_pkg::snr_byte_t i_threshold,  // spike threshold, ppm
  input  wire snr_pkg::snr_word_t i_passes,     // smoothing passes
  output logic                  o_valid,        // filter holds a value
  output snr_pkg::snr_word_t    o_value         // smoothed ppm
);
  import snr_pkg::*;

  snr_flt_state_e state_q;
  snr_word_t      avg_q;
  logic [2:0]     spike_cnt_q;

  // distance from the running value
  wire snr_word_t   diff      = (i_sample > avg_q) ? (i_sample - avg_q) : (avg_q - i_sample);
  wire logic        spike     = diff > {8'h00, i_threshold};
  wire logic        reseed    = spike_cnt_q == (`SNR_SPIKE_RESEED - 3'h1);
  // zero passes would divide by zero, so it behaves as one pass
  wire logic [32:0] n_eff     = (i_passes == 16'h0000) ? 33'h000000001 : {17'h00000, i_passes};
  wire logic [32:0] weighted  = {17'h00000, avg_q} * (n_eff - 33'h000000001) + {17'h00000, i_sample};
  wire logic [32:0] quotient  = weighted / n_eff;
  wire snr_word_t   avg_next  = quotient[15:0];

  // state and running value
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q     <= FLT_EMPTY;
      avg_q       <= 16'h0000;
      spike_cnt_q <= 3'h0;
    end else if (i_sample_valid) begin
      case (state_q)
        FLT_EMPTY: begin
          state_q <= FLT_RUN;
          avg_q   <= i_sample;
        end
        FLT_RUN: begin
          // RULE12 reject spike samples
          if (spike && !reseed) begin
            spike_cnt_q <= spike_cnt_q + 3'h1;
          end else if (spike) begin
            avg_q       <= i_sample;
            spike_cnt_q <= 3'h0;
          end else begin
            // RULE13 smoothing over passes
            avg_q       <= avg_next;
            spike_cnt_q <= 3'h0;
          end
        end
        default: begin
          state_q <= FLT_EMPTY;
        end
      endcase
    end
  end

  assign o_valid = state_q == FLT_RUN;
  assign o_value = avg_q;

endmodule // snr_filter

// ---- logic/snr_bank.sv ----
// holding register bank of the sensor node, reached by the register port of the serial protocol engine
`timescale 1ns/1ps
`include "snr_map.svh"

module snr_bank #(
  parameter logic [31:0] SERIAL_ID  = 32'h1234ABCD, // arbitrary value
  parameter logic [15:0] SW_VERSION = 16'h0101,     // arbitrary value
  parameter logic [7:0]  MODEL_CODE = 8'h11,        // arbitrary value
  parameter logic [7:0]  HW_REV     = 8'h01,        // arbitrary value
  parameter logic [7:0]  CTL_FW     = 8'h01,        // arbitrary value
  parameter logic [7:0]  HUM_VER    = 8'h01         // arbitrary value
) (
  input  wire logic               i_clock,          // node clock, 100 MHz
  input  wire logic               i_rst_n,          // synchronous reset, active low
  // register port
  input  wire logic               i_reg_rd,         // read strobe, one cycle
  input  wire logic               i_reg_wr,         // write strobe, one cycle
  input  wire snr_pkg::snr_byte_t i_reg_addr,       // register number
  input  wire snr_pkg::snr_word_t i_reg_wdata,      // write data, bytes in low bits
  output snr_pkg::snr_word_t      o_reg_rdata,      // read data
  output logic                    o_reg_ack,        // access done, one cycle
  // stored station address
  input  wire logic               i_stored_valid,   // a station address is stored
  input  wire snr_pkg::snr_byte_t i_stored_addr,    // stored station address
  // firmware loader
  input  wire logic               i_update_we,      // loader status strobe
  input  wire snr_pkg::snr_byte_t i_update_status,  // loader status value
  // converters
  input  wire snr_pkg::snr_word_t i_raw_gas_v,      // gas voltage output sample
  input  wire snr_pkg::snr_word_t i_raw_tmp_v,      // temperature voltage output sample
  input  wire snr_pkg::snr_word_t i_raw_hum_v,      // humidity voltage output sample
  input  wire snr_pkg::snr_word_t i_raw_gas_i,      // gas current output sample
  input  wire snr_pkg::snr_word_t i_raw_tmp_i,      // temperature current output sample
  input  wire snr_pkg::snr_byte_t i_raw_hum_i,      // humidity current output sample
  input  wire snr_pkg::snr_word_t i_raw_therm,      // thermistor sample
  input  wire snr_pkg::snr_word_t i_raw_light,      // light sensor sample
  input  wire snr_pkg::snr_word_t i_therm_tc,       // thermistor temperature, tenths C
  // gas sensor
  input  wire logic               i_gas_valid,      // gas sample strobe
  input  wire snr_pkg::snr_word_t i_gas_ppm,        // raw gas sample, ppm
  // humidity element
  input  wire logic               i_hum_valid,      // humidity sample strobe
  input  wire snr_pkg::snr_word_t i_hum_rh,         // relative humidity
  input  wire snr_pkg::snr_word_t i_hum_freq,       // element frequency
  input  wire snr_pkg::snr_word_t i_hum_tc,         // element temperature, tenths C
  // outputs to the rest of the node
  output snr_pkg::snr_byte_t      o_station_addr,   // station address in use
  output logic [16:0]             o_line_bps,       // selected line speed
  output snr_pkg::snr_word_t      o_gas_ppm,        // calibrated gas concentration
  output snr_pkg::snr_byte_t      o_gas_alarm       // gas alarm state
);
  import snr_pkg::*;

  // stored configuration
  snr_byte_t   station_q;
  logic        load_pend_q;
  snr_byte_t   conflict_q;
  snr_byte_t   speed_q;
  logic [16:0] bps_q;
  snr_byte_t   update_q;
  snr_word_t   gas_ofs_q;
  snr_byte_t   spike_q;
  snr_word_t   passes_q;
  snr_word_t   fair_q;
  snr_word_t   poor_q;
  snr_byte_t   hum_cal_q;
  // sampled state
  snr_word_t   raw_gas_v_q;
  snr_word_t   raw_tmp_v_q;
  snr_word_t   raw_hum_v_q;
  snr_word_t   raw_gas_i_q;
  snr_word_t   raw_tmp_i_q;
  snr_byte_t   raw_hum_i_q;
  snr_word_t   raw_therm_q;
  snr_word_t   raw_light_q;
  snr_word_t   therm_tc_q;
  snr_word_t   gas_conc_q;
  snr_byte_t   alarm_q;
  snr_word_t   hum_rh_q;
  snr_word_t   hum_freq_q;
  snr_word_t   hum_tc_q;
  snr_word_t   hum_tf_q;
  // bus answer
  snr_word_t   rdata_q;
  logic        ack_q;
  snr_word_t   rdata_d;

  // filtered gas value
  logic        flt_valid;
  snr_word_t   flt_value;

  snr_filter u_filter (
    .i_clock        (i_clock),
    .i_rst_n        (i_rst_n),
    .i_sample_valid (i_gas_valid),
    .i_sample       (i_gas_ppm),
    .i_threshold    (spike_q),
    .i_passes       (passes_q),
    .o_valid        (flt_valid),
    .o_value        (flt_value)
  );

  // write decode; locations not listed here take no write at all
  wire logic wr_station  = i_reg_wr && (i_reg_addr == `SNR_OFS_STATION);
  wire logic wr_conflict = i_reg_wr && (i_reg_addr == `SNR_OFS_CONFLICT);
  wire logic wr_speed    = i_reg_wr && (i_reg_addr == `SNR_OFS_SPEED);
  wire logic wr_update   = i_reg_wr && (i_reg_addr == `SNR_OFS_UPDATE);
  wire logic wr_conc     = i_reg_wr && (i_reg_addr == `SNR_OFS_GAS_CONC);
  wire logic wr_ofs      = i_reg_wr && (i_reg_addr == `SNR_OFS_GAS_OFS);
  wire logic wr_spike    = i_reg_wr && (i_reg_addr == `SNR_OFS_SPIKE);
  wire logic wr_passes   = i_reg_wr && (i_reg_addr == `SNR_OFS_PASSES);
  wire logic wr_fair     = i_reg_wr && (i_reg_addr == `SNR_OFS_FAIR);
  wire logic wr_poor     = i_reg_wr && (i_reg_addr == `SNR_OFS_POOR);
  wire logic wr_hum_cal  = i_reg_wr && (i_reg_addr == `SNR_OFS_HUM_CAL);

  // RULE2 speed code to bit rate
  wire logic        speed_ok  = i_reg_wdata[7:0] <= `SNR_SPEED_MAX;
  wire logic [16:0] bps_d     = (speed_q == 8'h00) ? `SNR_BPS_0 :
                                (speed_q == 8'h01) ? `SNR_BPS_1 :
                                (speed_q == 8'h02) ? `SNR_BPS_2 :
                                (speed_q == 8'h03) ? `SNR_BPS_3 : `SNR_BPS_4;

  // RULE10 calibration offset so the filtered value reads as the target
  wire snr_word_t   cal_ofs   = i_reg_wdata - flt_value;
  // calibrated concentration, clamped into 0..FFFF so a large offset cannot wrap
  wire logic signed [17:0] conc_sum = $signed({2'b00, flt_value}) + $signed({{2{gas_ofs_q[15]}}, gas_ofs_q});
  wire snr_word_t   conc_d    = conc_sum[17] ? 16'h0000 :
                                conc_sum[16] ? 16'hFFFF : conc_sum[15:0];

  // RULE15 alarm level, poor taking priority over fair
  wire logic        is_poor   = gas_conc_q >= poor_q;
  wire logic        is_fair   = !is_poor && (gas_conc_q >= fair_q);
  wire logic        is_good   = !is_poor && !is_fair;
  wire snr_byte_t   alarm_d   = ({7'h00, is_poor} << `SNR_ALARM_POOR) |
                                ({7'h00, is_fair} << `SNR_ALARM_FAIR) |
                                ({7'h00, is_good} << `SNR_ALARM_GOOD);

  // RULE18 fahrenheit from the same celsius sample
  wire logic signed [19:0] tc_ext = $signed({{4{i_hum_tc[15]}}, i_hum_tc});
  wire logic signed [19:0] tf_ext = (tc_ext * `SNR_F_MUL) / `SNR_F_DIV + `SNR_F_ADD;

  // station address and its stored value, caught one cycle after reset release
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      // RULE1 default station address
      station_q   <= `SNR_RST_STATION;
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
      if (wr_station) begin
        station_q <= i_reg_wdata[7:0];
      end else if (load_pend_q && i_stored_valid) begin
        // RULE1 stored address overrides
        station_q <= i_stored_addr;
      end
    end
  end

  // network configuration bytes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      conflict_q <= 8'h00;
      speed_q    <= `SNR_RST_SPEED;
      bps_q      <= `SNR_BPS_0;
    end else begin
      // RULE7 conflict slot written by master
      if (wr_conflict) begin
        conflict_q <= i_reg_wdata[7:0];
      end
      // codes above the table are ignored so the line never loses a valid speed
      if (wr_speed && speed_ok) begin
        speed_q <= i_reg_wdata[7:0];
      end
      bps_q <= bps_d;
    end
  end

  // firmware update status; the loader's report wins over a bus write in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      update_q <= 8'h00;
    end else if (i_update_we) begin
      // RULE8 loader reports progress
      update_q <= i_update_status;
    end else if (wr_update) begin
      update_q <= i_reg_wdata[7:0];
    end
  end

  // gas calibration offset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      gas_ofs_q <= 16'h0000;
    end else if (wr_conc) begin
      // RULE11 offset recomputed on concentration write
      gas_ofs_q <= cal_ofs;
    end else if (wr_ofs) begin
      // RULE11 offset written directly
      gas_ofs_q <= i_reg_wdata;
    end
  end

  // filter settings
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      spike_q  <= `SNR_RST_SPIKE;
      passes_q <= `SNR_RST_PASSES;
    end else begin
      // RULE12 spike threshold register
      if (wr_spike) begin
        spike_q <= i_reg_wdata[7:0];
      end
      // RULE13 smoothing passes register
      if (wr_passes) begin
        passes_q <= i_reg_wdata;
      end
    end
  end

  // RULE14 alarm thresholds
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fair_q <= `SNR_RST_FAIR;
      poor_q <= `SNR_RST_POOR;
    end else begin
      if (wr_fair) begin
        fair_q <= i_reg_wdata;
      end
      if (wr_poor) begin
        poor_q <= i_reg_wdata;
      end
    end
  end

  // RULE17 humidity calibration point count
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hum_cal_q <= 8'h00;
    end else if (wr_hum_cal) begin
      hum_cal_q <= i_reg_wdata[7:0];
    end
  end

  // RULE9 converter samples, never written from the bus
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      raw_gas_v_q <= 16'h0000;
      raw_tmp_v_q <= 16'h0000;
      raw_hum_v_q <= 16'h0000;
      raw_gas_i_q <= 16'h0000;
      raw_tmp_i_q <= 16'h0000;
      raw_hum_i_q <= 8'h00;
      raw_therm_q <= 16'h0000;
      raw_light_q <= 16'h0000;
      therm_tc_q  <= 16'h0000;
    end else begin
      raw_gas_v_q <= i_raw_gas_v;
      raw_tmp_v_q <= i_raw_tmp_v;
      raw_hum_v_q <= i_raw_hum_v;
      raw_gas_i_q <= i_raw_gas_i;
      raw_tmp_i_q <= i_raw_tmp_i;
      raw_hum_i_q <= i_raw_hum_i;
      raw_therm_q <= i_raw_therm;
      raw_light_q <= i_raw_light;
      therm_tc_q  <= i_therm_tc;
    end
  end

  // concentration and alarm follow the filter; both read zero until a first sample
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      gas_conc_q <= 16'h0000;
      alarm_q    <= 8'h00;
    end else if (flt_valid) begin
      gas_conc_q <= conc_d;
      alarm_q    <= alarm_d;
    end
  end

  // humidity element; both temperature units load on the same strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hum_rh_q   <= 16'h0000;
      hum_freq_q <= 16'h0000;
      hum_tc_q   <= 16'h0000;
      hum_tf_q   <= 16'h0000;
    end else if (i_hum_valid) begin
      // RULE16 frequency sampled, not writable
      hum_freq_q <= i_hum_freq;
      hum_rh_q   <= i_hum_rh;
      // RULE18 both units together
      hum_tc_q   <= i_hum_tc;
      hum_tf_q   <= tf_ext[15:0];
    end
  end

  // read selection; unlisted and reserved numbers fall to the zero default
  always_comb begin
    rdata_d = 16'h0000;
    case (i_reg_addr)
      // RULE3 serial identifier bytes
      `SNR_OFS_SERIAL0:   rdata_d = {8'h00, SERIAL_ID[7:0]};
      `SNR_OFS_SERIAL1:   rdata_d = {8'h00, SERIAL_ID[15:8]};
      `SNR_OFS_SERIAL2:   rdata_d = {8'h00, SERIAL_ID[23:16]};
      `SNR_OFS_SERIAL3:   rdata_d = {8'h00, SERIAL_ID[31:24]};
      // RULE4 software version bytes
      `SNR_OFS_SWVER_LO:  rdata_d = {8'h00, SW_VERSION[7:0]};
      `SNR_OFS_SWVER_HI:  rdata_d = {8'h00, SW_VERSION[15:8]};
      `SNR_OFS_STATION:   rdata_d = {8'h00, station_q};
      // RULE5 model code constant
      `SNR_OFS_MODEL:     rdata_d = {8'h00, MODEL_CODE};
      // RULE6 hardware revision constant
      `SNR_OFS_HWREV:     rdata_d = {8'h00, HW_REV};
      `SNR_OFS_CTLFW:     rdata_d = {8'h00, CTL_FW};
      `SNR_OFS_CONFLICT:  rdata_d = {8'h00, conflict_q};
      `SNR_OFS_SPEED:     rdata_d = {8'h00, speed_q};
      `SNR_OFS_UPDATE:    rdata_d = {8'h00, update_q};
      `SNR_OFS_RAW_GAS_V: rdata_d = raw_gas_v_q;
      `SNR_OFS_RAW_TMP_V: rdata_d = raw_tmp_v_q;
      `SNR_OFS_RAW_HUM_V: rdata_d = raw_hum_v_q;
      `SNR_OFS_RAW_GAS_I: rdata_d = raw_gas_i_q;
      `SNR_OFS_RAW_TMP_I: rdata_d = raw_tmp_i_q;
      `SNR_OFS_RAW_HUM_I: rdata_d = {8'h00, raw_hum_i_q};
      `SNR_OFS_RAW_THERM: rdata_d = raw_therm_q;
      `SNR_OFS_RAW_LIGHT: rdata_d = raw_light_q;
      `SNR_OFS_GAS_CONC:  rdata_d = gas_conc_q;
      `SNR_OFS_GAS_OFS:   rdata_d = gas_ofs_q;
      `SNR_OFS_SPIKE:     rdata_d = {8'h00, spike_q};
      `SNR_OFS_PASSES:    rdata_d = passes_q;
      `SNR_OFS_FAIR:      rdata_d = fair_q;
      `SNR_OFS_POOR:      rdata_d = poor_q;
      `SNR_OFS_ALARM:     rdata_d = {8'h00, alarm_q};
      `SNR_OFS_HUM_VER:   rdata_d = {8'h00, HUM_VER};
      `SNR_OFS_RH:        rdata_d = hum_rh_q;
      `SNR_OFS_HUM_FREQ:  rdata_d = hum_freq_q;
      `SNR_OFS_HUM_CAL:   rdata_d = {8'h00, hum_cal_q};
      `SNR_OFS_HUM_TC:    rdata_d = hum_tc_q;
      `SNR_OFS_HUM_TF:    rdata_d = hum_tf_q;
      `SNR_OFS_THERM_TC:  rdata_d = therm_tc_q;
      // RULE20 reserved range reads zero
      default:            rdata_d = 16'h0000;
    endcase
  end

  // bus answer one cycle after the strobe; a write to a read-only number is answered the same way
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else begin
      // RULE19 every access acknowledged
      ack_q   <= i_reg_rd || i_reg_wr;
      rdata_q <= i_reg_rd ? rdata_d : 16'h0000;
    end
  end

  assign o_reg_rdata    = rdata_q;
  assign o_reg_ack      = ack_q;
  assign o_station_addr = station_q;
  assign o_line_bps     = bps_q;
  assign o_gas_ppm      = gas_conc_q;
  assign o_gas_alarm    = alarm_q;

endmodule // snr_bank

// ---- bench/snr_bank_monitor.sv ----
// port checker for the sensor node register bank
`timescale 1ns/1ps
module snr_bank_monitor #(
  parameter logic [31:0] SERIAL_ID  = 32'h0, // arbitrary value
  parameter logic [7:0]  MODEL_CODE = 8'h0   // arbitrary value
) (
  input wire logic               i_clock,        // node clock
  input wire logic               i_rst_n,        // reset, active low
  input wire logic               i_reg_rd,       // read strobe
  input wire logic               i_reg_wr,       // write strobe
  input wire snr_pkg::snr_byte_t i_reg_addr,     // register number
  input wire snr_pkg::snr_word_t o_reg_rdata,    // read data
  input wire logic               o_reg_ack,      // access done
  input wire snr_pkg::snr_byte_t o_station_addr, // station address
  input wire logic [16:0]        o_line_bps,     // line speed
  input wire snr_pkg::snr_byte_t o_gas_alarm     // alarm state
);
  import snr_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // every access answered next cycle, nothing answered unasked
  property p_ack; (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_idle; !(i_reg_rd || i_reg_wr) |=> !o_reg_ack && o_reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("answer without access");
  property p_wr0; i_reg_wr |=> o_reg_rdata == 16'h0000; endproperty
  a_wr0: assert property (p_wr0) else $error("write returned data");
  // outputs seen at release still hold their reset values
  property p_rst; $rose(i_rst_n) |-> o_station_addr == 8'hFE && o_line_bps == 17'h02580; endproperty
  a_rst: assert property (p_rst) else $error("bad reset station or speed");
  property p_bps; $changed(o_line_bps) |-> $past(i_reg_wr && i_reg_addr == 8'h0F, 1)
    || $past(i_reg_wr && i_reg_addr == 8'h0F, 2); endproperty
  a_bps: assert property (p_bps) else $error("speed changed without write");
  property p_alarm; o_gas_alarm inside {8'h00, 8'h02, 8'h04, 8'h08}; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm code not exclusive");
  property p_rsvd; i_reg_rd && i_reg_addr >= 8'h11 && i_reg_addr <= 8'h63 |=> o_reg_rdata == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_serial; i_reg_rd && i_reg_addr <= 8'h03 |=>
    o_reg_rdata[7:0] == 8'(SERIAL_ID >> (8 * $past(i_reg_addr[1:0]))); endproperty
  a_serial: assert property (p_serial) else $error("serial byte wrong");
  property p_model; i_reg_rd && i_reg_addr == 8'h07 |=> o_reg_rdata[7:0] == MODEL_CODE; endproperty
  a_model: assert property (p_model) else $error("model code wrong");
endmodule // snr_bank_monitor

bind snr_bank snr_bank_monitor #(.SERIAL_ID(SERIAL_ID), .MODEL_CODE(MODEL_CODE)) i_snr_bank_monitor (
  .i_clock, .i_rst_n, .i_reg_rd, .i_reg_wr, .i_reg_addr, .o_reg_rdata, .o_reg_ack,
  .o_station_addr, .o_line_bps, .o_gas_alarm);

// ---- bench/snr_master.sv ----
// network master model issuing register accesses
`timescale 1ns/1ps
module snr_master (
  input  wire logic               i_clock, // node clock
  input  wire logic               i_ack,   // access done
  input  wire snr_pkg::snr_word_t i_rdata, // read data
  output logic                    o_rd = 1'b0,     // read strobe
  output logic                    o_wr = 1'b0,     // write strobe
  output snr_pkg::snr_byte_t      o_addr = 8'h00,  // register number
  output snr_pkg::snr_word_t      o_wdata = 16'h0000 // write data
);
  import snr_pkg::*;
  // one-cycle strobe, then a bounded wait; a lost answer ends the run
  task automatic xfer(input logic w, input snr_byte_t a, input snr_word_t wd, output snr_word_t rd);
    int n;
    @(posedge i_clock);
    o_rd    <= !w;
    o_wr    <= w;
    o_addr  <= a;
    o_wdata <= wd;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    for (n = 0; n < 4 && i_ack !== 1'b1; n++) @(posedge i_clock);
    if (i_ack !== 1'b1) begin
      tb.n_fail++;
      tb.finish_test();
    end
    rd = i_rdata;
  endtask
endmodule // snr_master

// ---- bench/tb.sv ----
// self-checking bench for the sensor node register bank
`timescale 1ns/1ps
module tb;
  import snr_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        rd, wr, ack;
  logic        upd = 1'b0, gv = 1'b0, hv = 1'b0, sv = 1'b0;
  snr_byte_t   addr, alarm, station, ust = 8'h00;
  snr_word_t   wdata, rdata, ppm, d, gas = 16'h0000, htc = 16'h0000;
  snr_word_t   raw = 16'h1357, hfreq = 16'h1A2B;
  logic [16:0] bps;
  int          n_fail = 0;
  int          compares = 0;
  snr_byte_t   ra [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h6A, 8'h6B};
  snr_word_t   re [10] = '{16'h07, 16'h1E, 16'hC3, 16'hA5, 16'h71, 16'h2B, 16'h5A, 16'h3C, 16'h1357, 16'hECA8};
  logic [16:0] tab [6] = '{17'h02580, 17'h04B00, 17'h09600, 17'h0E100, 17'h1C200, 17'h1C200};
  always #5 i_clock = ~i_clock;
  // identity values below are arbitrary
  snr_bank #(.SERIAL_ID(32'hA5C31E07), .SW_VERSION(16'h2B71), .MODEL_CODE(8'h5A), .HW_REV(8'h3C)) i_snr_bank (
    .i_clock, .i_rst_n, .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .i_stored_valid(sv), .i_stored_addr(ust),
    .i_update_we(upd), .i_update_status(ust), .i_raw_gas_v(raw), .i_raw_tmp_v(raw), .i_raw_hum_v(raw),
    .i_raw_gas_i(raw), .i_raw_tmp_i(raw), .i_raw_hum_i(raw[7:0]), .i_raw_therm(raw), .i_raw_light(~raw),
    .i_therm_tc(raw), .i_gas_valid(gv), .i_gas_ppm(gas), .i_hum_valid(hv), .i_hum_rh(raw), .i_hum_freq(hfreq),
    .i_hum_tc(htc), .o_station_addr(station), .o_line_bps(bps), .o_gas_ppm(ppm), .o_gas_alarm(alarm));
  snr_master i_snr_master (.i_clock, .i_ack(ack), .i_rdata(rdata), .o_rd(rd), .o_wr(wr), .o_addr(addr),
    .o_wdata(wdata));
  task automatic check(input string nm, input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic w(input snr_byte_t a, input snr_word_t v);
    i_snr_master.xfer(1'b1, a, v, d);
  endtask
  task automatic rr(input snr_byte_t a, input snr_word_t e, input string nm);
    i_snr_master.xfer(1'b0, a, 16'h0000, d);
    check(nm, 17'(d), 17'(e));
  endtask
  task automatic gas_in(input snr_word_t s);
    @(posedge i_clock);
    gas <= s;
    gv  <= 1'b1;
    @(posedge i_clock);
    gv <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic t_reset();
    rr(8'h06, 16'h00FE, "station");
    check("bps", bps, 17'h02580);
    rr(8'h6E, 16'h00C8, "spike");
    rr(8'h6F, 16'h0005, "passes");
  endtask
  task automatic t_speed();
    for (int c = 0; c < 6; c++) begin
      w(8'h0F, 16'(c));
      @(posedge i_clock);
      check("bps", bps, tab[c]);
    end
  endtask
  task automatic t_ro();
    for (int i = 0; i < 10; i++) begin
      w(ra[i], 16'hFFFF);
      rr(ra[i], re[i], "ro");
    end
    w(8'h32, 16'h00AA);
    rr(8'h32, 16'h0000, "rsvd");
  endtask
  task automatic t_misc();
    w(8'h0A, 16'h0033);
    rr(8'h0A, 16'h0033, "slot");
    w(8'h76, 16'h0007);
    rr(8'h76, 16'h0007, "calpts");
    @(posedge i_clock);
    upd <= 1'b1;
    ust <= 8'h42;
    @(posedge i_clock);
    upd <= 1'b0;
    rr(8'h10, 16'h0042, "update");
    @(posedge i_clock);
    htc <= 16'd250;
    hv  <= 1'b1;
    @(posedge i_clock);
    hv <= 1'b0;
    w(8'h75, 16'hFFFF);
    rr(8'h75, 16'h1A2B, "freq");
    rr(8'h77, 16'd250, "tc");
    rr(8'h78, 16'd770, "tf");
  endtask
  task automatic t_gas();
    gas_in(16'd800);
    check("ppm", 17'(ppm), 17'd800);
    check("alarm", 17'(alarm), 17'h02);
    w(8'h70, 16'd700);
    repeat (2) @(posedge i_clock);
    check("alarm", 17'(alarm), 17'h04);
    w(8'h71, 16'd750);
    repeat (2) @(posedge i_clock);
    check("alarm", 17'(alarm), 17'h08);
    w(8'h6C, 16'd1000);
    repeat (2) @(posedge i_clock);
    check("ppm", 17'(ppm), 17'd1000);
    rr(8'h6D, 16'd200, "offset");
    gas_in(16'd1300);
    check("ppm", 17'(ppm), 17'd1000);
    gas_in(16'd900);
    check("ppm", 17'(ppm), 17'd1020);
    w(8'h6D, 16'h0000);
    repeat (2) @(posedge i_clock);
    check("ppm", 17'(ppm), 17'd820);
  endtask
  task automatic t_store();
    i_rst_n <= 1'b0;
    sv      <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    check("station", 17'(station), 17'h00042);
    rr(8'h06, 16'h0042, "station");
  endtask
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_speed();
    t_ro();
    t_misc();
    t_gas();
    t_store();
    finish_test();
  end
endmodule // tb
